//--- design/jtp_tap.sv
// Boundary-scan test access port with id, user code, scan chain and trace access
// How it works
// - Instruction register shifts exactly ten bits
// - User code register, 32 bits, shifts out
// - Scan chain length fixed per family size
// - Id fields: version, part, maker, one
// - Id least significant bit always one
// - Trace buffer captures internals, read over port
`include "jtp_regs.svh"
`default_nettype none
module jtp_tap
	import jtp_pkg::*;
#(
	parameter int BSR_LEN = `JTP_BSR_LEN_MIN,
	// Arbitrary value
	parameter logic [3:0] ID_VERSION = 4'h5,
	// Arbitrary value
	parameter logic [15:0] ID_PART = 16'h1234,
	// Arbitrary value
	parameter logic [10:0] ID_MAKER = 11'h055,
	parameter logic [31:0] USER_CODE = 32'hFFFFFFFF,
	parameter int TRACE_W = `JTP_TRACE_W,
	parameter int TRACE_DEPTH = `JTP_TRACE_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Test pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo,
	output logic tdo_oe,
	// Boundary cells
	input wire logic [BSR_LEN-1:0] pin_in,
	output logic [BSR_LEN-1:0] pin_out,
	output logic extest,
	// Trace probes
	input wire logic [TRACE_W-1:0] probe
);
	localparam int TI = $clog2(TRACE_DEPTH);
	localparam int TL = TRACE_W * TRACE_DEPTH;

	logic [2:0] tck_s, tms_s, tdi_s, trst_s;
	logic rise, fall, ms, di, trst;
	jtp_state_t state, next_state;
	logic [`JTP_IR_LEN-1:0] ir_sh, ir;
	logic [31:0] dr32;
	logic bypass_bit;
	logic [BSR_LEN-1:0] bsr;
	logic [TL-1:0] tr_sh;
	logic [TI:0] tr_load;
	logic tr_loading, tr_arm, tr_done;
	logic [TRACE_W-1:0] tr_data;
	jtp_sel_t sel;

	// Two flops per pin, then a third for edge finding
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tck_s <= 3'h0;
			tms_s <= 3'h7;
			tdi_s <= 3'h7;
			trst_s <= 3'h0;
		end else begin
			tck_s <= {tck_s[1:0], tck};
			tms_s <= {tms_s[1:0], tms};
			tdi_s <= {tdi_s[1:0], tdi};
			trst_s <= {trst_s[1:0], trst_n};
		end
	end
	assign rise = tck_s[1] & ~tck_s[2];
	assign fall = ~tck_s[1] & tck_s[2];
	assign ms = tms_s[1];
	assign di = tdi_s[1];
	assign trst = ~trst_s[1];

	function automatic jtp_sel_t decode(input logic [`JTP_IR_LEN-1:0] op);
		if (op == `JTP_OP_IDCODE) decode = SEL_ID;
		else if (op == `JTP_OP_USERCODE) decode = SEL_USER;
		else if (op == `JTP_OP_EXTEST || op == `JTP_OP_SAMPLE) decode = SEL_BSR;
		else if (op == `JTP_OP_ANALYZER) decode = SEL_TRACE;
		else decode = SEL_BYPASS;
	endfunction
	assign sel = decode(ir);

	always_comb begin
		next_state = state;
		case (state)
			ST_RESET: next_state = ms ? ST_RESET : ST_IDLE;
			ST_IDLE: next_state = ms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: next_state = ms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: next_state = ms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: next_state = ms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: next_state = ms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: next_state = ms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: next_state = ms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: next_state = ms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: next_state = ms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: next_state = ms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: next_state = ms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: next_state = ms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: next_state = ms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: next_state = ms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: next_state = ms ? ST_SEL_DR : ST_IDLE;
			default: next_state = ST_RESET;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n || trst) begin
			state <= ST_RESET;
		end else if (rise) begin
			state <= next_state;
		end
	end

	// Instruction path: shift register plus latched copy
	always_ff @(posedge clock) begin
		if (!rst_n || trst) begin
			ir_sh <= `JTP_IR_RESET;
			ir <= `JTP_OP_IDCODE;
		end else if (rise) begin
			case (state)
				ST_RESET: ir <= `JTP_OP_IDCODE;
				ST_CAP_IR: ir_sh <= `JTP_IR_CAPTURE;
				ST_SH_IR: ir_sh <= {di, ir_sh[`JTP_IR_LEN-1:1]};
				ST_UPD_IR: ir <= ir_sh;
				default: ;
			endcase
		end
	end

	// 32-bit path shared by id and user code
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dr32 <= 32'h0;
			bypass_bit <= 1'b0;
		end else if (rise) begin
			if (state == ST_CAP_DR) begin
				bypass_bit <= 1'b0;
				if (sel == SEL_USER) begin
					dr32 <= USER_CODE;
				end else begin
					dr32 <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
				end
			end else if (state == ST_SH_DR) begin
				bypass_bit <= di;
				dr32 <= {di, dr32[31:1]};
			end
		end
	end

	// Scan chain of fixed length; update loads pin_out, extest says pins follow it
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bsr <= '0;
			pin_out <= '0;
		end else if (rise && sel == SEL_BSR) begin
			if (state == ST_CAP_DR) begin
				bsr <= pin_in;
			end else if (state == ST_SH_DR) begin
				bsr <= {di, bsr[BSR_LEN-1:1]};
			end else if (state == ST_UPD_DR) begin
				pin_out <= bsr;
			end
		end
	end
	assign extest = (ir == `JTP_OP_EXTEST);

	// Trace: update arms a fresh run; capture copies buffer into the chain
	assign tr_arm = rise && state == ST_UPD_DR && sel == SEL_TRACE;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tr_sh <= '0;
			tr_load <= '0;
			tr_loading <= 1'b0;
		end else if (tr_loading) begin
			// Copy takes seventeen fast clocks; test clock high phase must outlast it
			tr_sh <= {tr_data, tr_sh[TL-1:TRACE_W]};
			tr_load <= tr_load + 1'b1;
			if (tr_load == (TI + 1)'(TRACE_DEPTH)) begin
				tr_loading <= 1'b0;
			end
		end else if (rise && sel == SEL_TRACE) begin
			if (state == ST_CAP_DR && tr_done) begin
				tr_loading <= 1'b1;
				tr_load <= '0;
			end else if (state == ST_SH_DR) begin
				tr_sh <= {di, tr_sh[TL-1:1]};
			end
		end
	end

	jtp_trace #(.WIDTH(TRACE_W), .DEPTH(TRACE_DEPTH)) u_trace (
		.clock(clock),
		.rst_n(rst_n),
		.probe(probe),
		.arm(tr_arm),
		.rd_index(tr_load[TI-1:0]),
		.rd_data(tr_data),
		.done(tr_done)
	);

	// Output changes on falling test clock in every state; enable is set only in shift states
	always_ff @(posedge clock) begin
		if (!rst_n || trst) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (fall) begin
			tdo_oe <= (state == ST_SH_DR) || (state == ST_SH_IR);
			if (state == ST_SH_IR) begin
				tdo <= ir_sh[0];
			end else begin
				case (sel)
					SEL_ID, SEL_USER: tdo <= dr32[0];
					SEL_BSR: tdo <= bsr[0];
					SEL_TRACE: tdo <= tr_sh[0];
					default: tdo <= bypass_bit;
				endcase
			end
		end
	end
endmodule // jtp_tap
`default_nettype wire

//--- design/jtp_regs.svh
// Constants for the test access port: lengths, codes and instruction values
`ifndef JTP_REGS_SVH
`define JTP_REGS_SVH
`define JTP_IR_LEN 10
`define JTP_DR32_LEN 32
`define JTP_BSR_LEN_MIN 1164
`define JTP_BSR_LEN_MID 1506
`define JTP_BSR_LEN_MAX 2190
`define JTP_ID_VER_W 4
`define JTP_ID_PART_W 16
`define JTP_ID_MFR_W 11
`define JTP_ID_VER_POS 28
`define JTP_ID_PART_POS 12
`define JTP_ID_MFR_POS 1
`define JTP_IR_CAPTURE 10'h001
`define JTP_IR_RESET 10'h3FF
`define JTP_OP_EXTEST 10'h000
`define JTP_OP_SAMPLE 10'h005
`define JTP_OP_IDCODE 10'h006
`define JTP_OP_USERCODE 10'h007
`define JTP_OP_ANALYZER 10'h00E
`define JTP_OP_BYPASS 10'h3FF
`define JTP_TRACE_DEPTH 16
`define JTP_TRACE_W 8
`endif

//--- design/jtp_pkg.sv
// Types for the test access port
`default_nettype none
package jtp_pkg;
	typedef enum logic [3:0] {
		ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
		ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
		ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB,
		ST_EX1_IR = 4'hC, ST_PAU_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF
	} jtp_state_t;
	typedef enum logic [2:0] {
		SEL_BYPASS = 3'h0, SEL_ID = 3'h1, SEL_USER = 3'h2, SEL_BSR = 3'h3, SEL_TRACE = 3'h4
	} jtp_sel_t;
endpackage
`default_nettype wire

//--- design/jtp_trace.sv
// Embedded trace capture: samples internal signals at full clock rate
`default_nettype none
module jtp_trace
	import jtp_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Watched logic
	input wire logic [WIDTH-1:0] probe,
	input wire logic arm,
	// Readout
	input wire logic [$clog2(DEPTH)-1:0] rd_index,
	output logic [WIDTH-1:0] rd_data,
	output logic done
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [$clog2(DEPTH)-1:0] wr_index;
	logic running;

	// Capture every cycle while armed, stop when full
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			running <= 1'b0;
			wr_index <= '0;
			done <= 1'b0;
		end else if (arm) begin
			running <= 1'b1;
			wr_index <= '0;
			done <= 1'b0;
		end else if (running) begin
			wr_index <= wr_index + 1'b1;
			if (wr_index == $clog2(DEPTH)'(DEPTH - 1)) begin
				running <= 1'b0;
				done <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (running) begin
			mem[wr_index] <= probe;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_index];
		end
	end
endmodule // jtp_trace
`default_nettype wire

//--- tb/jtp_tap_asserts.sv
// Port checks for the test access port
`include "jtp_regs.svh"
`default_nettype none
module jtp_tap_asserts #(
	parameter int BSR_LEN = `JTP_BSR_LEN_MIN
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Test pins
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic extest,
	// Boundary outputs
	input wire logic [BSR_LEN-1:0] pin_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [7:0] hist;
	// Raw tck history, newest in bit 0; wide enough for the synchroniser lag
	always_ff @(posedge clock) begin
		hist <= {hist[6:0], tck};
	end
	wire fell_near = |(hist[7:1] & ~hist[6:0]);
	wire rose_near = |(~hist[7:1] & hist[6:0]);
	sequence s_trst_held;
		!trst_n [*5];
	endsequence
	property p_rst_quiet;
		disable iff (1'b0) !rst_n ##1 !rst_n |-> !tdo && !tdo_oe;
	endproperty
	property p_trst_clears;
		s_trst_held |=> !extest && !tdo_oe;
	endproperty
	property p_tdo_on_fall;
		$changed(tdo) && trst_n |-> fell_near;
	endproperty
	property p_oe_on_fall;
		$changed(tdo_oe) && trst_n |-> fell_near;
	endproperty
	property p_extest_on_rise;
		$rose(extest) |-> rose_near;
	endproperty
	property p_pin_out_on_rise;
		$changed(pin_out) |-> rose_near;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live in reset");
	a_trst_clears: assert property (p_trst_clears) else $error("trst ignored");
	a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo off fall");
	a_oe_on_fall: assert property (p_oe_on_fall) else $error("oe off fall");
	a_extest_on_rise: assert property (p_extest_on_rise) else $error("extest off rise");
	a_pin_out_on_rise: assert property (p_pin_out_on_rise) else $error("pin_out off rise");
endmodule // jtp_tap_asserts
`default_nettype wire

//--- tb/jtp_ctrl.sv
// Behavioural boundary-scan controller
`default_nettype none
module jtp_ctrl (
	// Test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		tck <= 1'b0;
		tms <= 1'b1;
		tdi <= 1'b0;
	end
	// Tck idles low between frames; tdo taken at the rise
	task automatic step(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		#80 tck <= 1'b1;
		q = tdo;
		#80 tck <= 1'b0;
	endtask
	// Idle, shift n bits LSB first, update, idle; unused tdi toggles
	task automatic scan(input logic ir, input int n, input logic [2199:0] din,
		output logic [2199:0] dout);
		logic q;
		dout = '0;
		step(1'b1, ~tdi, q);
		if (ir) begin
			step(1'b1, ~tdi, q);
		end
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
	// Five high mode cycles reach reset from anywhere
	task automatic to_reset();
		logic q;
		repeat (5) step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
endmodule // jtp_ctrl
`default_nettype wire

//--- tb/test_jtag_test_access_port.sv
// Testbench for the test access port
`include "jtp_regs.svh"
`default_nettype none
module test_jtag_test_access_port;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BL = 1164;
	localparam logic [31:0] UCODE = 32'hA5C30F96;
	// Arbitrary identity fields
	localparam logic [3:0] IDV = 4'h5;
	localparam logic [15:0] IDP = 16'h1234;
	localparam logic [10:0] IDM = 11'h055;
	logic clock, rst_n, trst_n, tck, tms, tdi, tdo, tdo_oe, extest;
	logic [BL-1:0] pin_in, pin_out;
	logic [7:0] probe;
	logic [2199:0] din, dout;
	int mismatches, check_count;
	jtp_tap #(.BSR_LEN(BL), .ID_VERSION(IDV), .ID_PART(IDP), .ID_MAKER(IDM),
		.USER_CODE(UCODE)) u_jtp_tap (.clock(clock), .rst_n(rst_n),
		.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
		.pin_in(pin_in), .pin_out(pin_out), .extest(extest), .probe(probe));
	jtp_ctrl u_jtp_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) probe <= rst_n ? probe + 8'h01 : 8'h00;
	task automatic check(input string what, input logic [2199:0] exp, input logic [2199:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic load(input logic [9:0] op);
		din = '0;
		din[9:0] = op;
		u_jtp_ctrl.scan(1'b1, 10, din, dout);
	endtask
	task automatic t_id();
		u_jtp_ctrl.scan(1'b0, 32, '0, dout);
		check("idcode", {IDV, IDP, IDM, 1'b1}, dout[31:0]);
		$display("t_id done");
	endtask
	// Twenty bits: capture value, then the first ten come back out
	task automatic t_ir();
		din = '0;
		din[19:0] = {`JTP_OP_USERCODE, 10'h2B5};
		u_jtp_ctrl.scan(1'b1, 20, din, dout);
		check("ir", {10'h2B5, `JTP_IR_CAPTURE}, dout[19:0]);
		u_jtp_ctrl.scan(1'b0, 32, '0, dout);
		check("usercode", UCODE, dout[31:0]);
		$display("t_ir done");
	endtask
	task automatic t_bsr();
		load(`JTP_OP_SAMPLE);
		din = '0;
		for (int i = 0; i < BL + 8; i++) begin
			din[i] = i[0] ^ i[4];
		end
		u_jtp_ctrl.scan(1'b0, BL + 8, din, dout);
		check("capture", pin_in, dout[BL-1:0]);
		check("tail", din[7:0], dout[BL+7:BL]);
		check("update", din[BL+7:8], pin_out);
		load(`JTP_OP_EXTEST);
		check("extest", 1'b1, extest);
		u_jtp_ctrl.to_reset();
		check("extest_off", 1'b0, extest);
		$display("t_bsr done");
	endtask
	// Probe counts once a clock, so stored words step by one
	task automatic t_trace();
		logic [7:0] w;
		load(`JTP_OP_ANALYZER);
		u_jtp_ctrl.scan(1'b0, 1, '0, dout);
		u_jtp_ctrl.scan(1'b0, 128, '0, dout);
		for (int k = 1; k < 16; k++) begin
			w = dout[k*8 +: 8] - dout[k*8-8 +: 8];
			check("trace_step", 8'h01, w);
		end
		$display("t_trace done");
	endtask
	// Bypass captures zero, then delays tdi by one bit
	task automatic t_bypass();
		load(`JTP_OP_BYPASS);
		din = '0;
		din[7:0] = 8'hB6;
		u_jtp_ctrl.scan(1'b0, 9, din, dout);
		check("bypass", {8'hB6, 1'b0}, dout[8:0]);
		check("oe_idle", 1'b0, tdo_oe);
		$display("t_bypass done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		end_sim();
	end
	initial begin
		rst_n = 1'b0;
		trst_n = 1'b1;
		pin_in = {97{12'hC35}};
		mismatches = 0;
		check_count = 0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		u_jtp_ctrl.to_reset();
		t_id();
		t_ir();
		t_bsr();
		t_trace();
		t_bypass();
		load(`JTP_OP_EXTEST);
		check("extest_on", 1'b1, extest);
		trst_n <= 1'b0;
		repeat (6) @(posedge clock);
		trst_n <= 1'b1;
		repeat (4) @(posedge clock);
		check("trst_extest", 1'b0, extest);
		u_jtp_ctrl.to_reset();
		t_id();
		end_sim();
	end
endmodule // test_jtag_test_access_port
bind jtp_tap jtp_tap_asserts #(.BSR_LEN(BSR_LEN)) u_jtp_tap_asserts (.clock(clock),
	.rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
	.extest(extest), .pin_out(pin_out));
`default_nettype wire
